//--- srm_pkg.sv
package srm_pkg;

  // instruction word, bit 0 of the encoding is the most significant bit here
  typedef struct packed {
    logic [5:0] opcd;
    logic [4:0] src_idx;
    logic [4:0] tgt_idx;
    logic [4:0] cnt_idx;
    logic [9:0] xo;
    logic record_flag;
  } srm_insn_t;

  // condition field 0, less-than in the top bit
  typedef struct packed {
    logic less_than_zero_flag;
    logic greater_than_zero_flag;
    logic zero_result_flag;
    logic summary_ovf;
  } srm_cr0_t;

  // write-back to the general register file
  typedef struct packed {
    logic [4:0] idx;
    logic [31:0] data;
  } srm_wb_t;

  typedef enum logic [1:0] {
    SRM_OP_NONE = 2'h0,
    SRM_OP_LONG_IMM = 2'h1,
    SRM_OP_LONG_REG = 2'h2,
    SRM_OP_SAVE = 2'h3
  } srm_op_t;

  // gray codes along idle -> exec -> done; done -> idle flips both bits
  typedef enum logic [1:0] {
    SRM_ST_IDLE = 2'h0,
    SRM_ST_EXEC = 2'h1,
    SRM_ST_DONE = 2'h3
  } srm_state_t;

  localparam logic [5:0] SRM_PRIMARY_OPCD = 6'h1f;
  localparam logic [9:0] SRM_XO_LONG_IMM = 10'h2f8;
  localparam logic [9:0] SRM_XO_LONG_REG = 10'h2d8;
  localparam logic [9:0] SRM_XO_SAVE = 10'h298;

  localparam int SRM_WORD_W = 32;
  localparam int SRM_CNT_LSB = 0;
  localparam int SRM_CNT_MSB = 4;
  localparam int SRM_CNT_MODE_BIT = 5;

  // register byte offsets
  localparam logic [4:0] SRM_REG_CTRL = 5'h00;
  localparam logic [4:0] SRM_REG_INSN = 5'h04;
  localparam logic [4:0] SRM_REG_SRC = 5'h08;
  localparam logic [4:0] SRM_REG_CNT = 5'h0c;
  localparam logic [4:0] SRM_REG_AUX = 5'h10;
  localparam logic [4:0] SRM_REG_RESULT = 5'h14;
  localparam logic [4:0] SRM_REG_STATUS = 5'h18;
  localparam logic [4:0] SRM_REG_SO = 5'h1c;

  // control and status fields
  localparam int SRM_CTRL_GO = 0;
  localparam int SRM_CTRL_CLR = 1;
  localparam int SRM_ST_BUSY = 4;
  localparam int SRM_ST_DONE_BIT = 5;
  localparam int SRM_ST_ILL = 6;
  localparam int SRM_ST_AUXW = 7;
  localparam int SRM_ST_IDX_LSB = 8;
  localparam int SRM_ST_CR0W = 13;

  localparam logic [31:0] SRM_AUX_RST = 32'h0000_0000;
  localparam logic [31:0] SRM_ONES = 32'hffff_ffff;

endpackage

//--- srm_unit.sv
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
// Functional notes
// - immediate long form saves rotated word to auxiliary
// - immediate long form merges rotated with auxiliary under mask
// - register long form rotates by count bits 27-31
// - register long, mode clear: merge rotated, ones-tail mask
// - register long, mode set: merge zeros, ones-head mask
// - register long form writes target, keeps auxiliary
// - save form stores rotated word in auxiliary
// - save form mask zero when count bit 26 set
// - save form target gets rotated AND mask
// - record flag set updates condition field 0 only
// - exception register is never touched
module srm_unit (
  input wire logic mclk,
  input wire logic rst_n,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // write-back towards the general register file
  output logic rf_wr_stb,
  output srm_pkg::srm_wb_t rf_wr,
  // condition field 0 update
  output logic cr0_wr_stb,
  output srm_pkg::srm_cr0_t cr0_wr
);
  import srm_pkg::*;

  srm_state_t state_q;
  srm_state_t state_d;
  logic ack_q;
  logic [31:0] rdata_q;
  srm_insn_t insn_q;
  logic [31:0] src_q;
  logic [31:0] cnt_q;
  logic [31:0] aux_q;
  logic [31:0] result_q;
  srm_cr0_t cr0_q;
  logic so_q;
  logic done_q;
  logic ill_q;
  logic aux_wr_q;
  logic cr0_wr_q;
  logic rf_wr_stb_q;
  srm_wb_t rf_wr_q;
  logic cr0_wr_stb_q;
  srm_cr0_t cr0_wr_data_q;

  logic bus_req;
  logic bus_wr;
  logic go_req;
  logic clr_req;
  srm_op_t op;
  logic [4:0] shamt;
  logic mode_bit;
  logic [31:0] rot;
  logic [31:0] tail_mask;
  logic [31:0] mask;
  logic [31:0] merge_src;
  logic [31:0] res;
  logic aux_we;
  logic [63:0] dbl;
  srm_cr0_t cr0_new;

  // byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old,
    input logic [31:0] wdat,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // one request taken per ack; ack_q blocks the repeat edge
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr = bus_req && wb_we_i;
  assign go_req = bus_wr && (wb_adr_i == SRM_REG_CTRL) && wb_sel_i[0]
                  && wb_dat_i[SRM_CTRL_GO];
  assign clr_req = bus_wr && (wb_adr_i == SRM_REG_CTRL) && wb_sel_i[0]
                   && wb_dat_i[SRM_CTRL_CLR];

  // decode
  always_comb begin
    op = SRM_OP_NONE;
    if (insn_q.opcd == SRM_PRIMARY_OPCD) begin
      case (insn_q.xo)
        SRM_XO_LONG_IMM: op = SRM_OP_LONG_IMM;
        SRM_XO_LONG_REG: op = SRM_OP_LONG_REG;
        SRM_XO_SAVE: op = SRM_OP_SAVE;
        default: op = SRM_OP_NONE;
      endcase
    end
  end

  // shift amount: immediate field or low count bits
  always_comb begin
    if (op == SRM_OP_LONG_IMM) begin
      shamt = insn_q.cnt_idx;
    end else begin
      shamt = cnt_q[SRM_CNT_MSB:SRM_CNT_LSB];
    end
    mode_bit = cnt_q[SRM_CNT_MODE_BIT];
  end

  // rotate left by 32-n equals rotate right by n; n=0 leaves it whole
  assign dbl = {src_q, src_q} >> shamt;
  assign rot = dbl[SRM_WORD_W-1:0];
  // n zeros then 32-n ones, counting from the most significant bit
  assign tail_mask = SRM_ONES >> shamt;

  // mask and merge per operation
  always_comb begin
    mask = tail_mask;
    merge_src = rot;
    res = '0;
    aux_we = 1'b0;
    case (op)
      SRM_OP_LONG_IMM: begin
        mask = tail_mask;
        merge_src = rot;
        res = (merge_src & mask) | (aux_q & ~mask);
        aux_we = 1'b1;
      end
      SRM_OP_LONG_REG: begin
        if (mode_bit) begin
          mask = ~tail_mask;
          merge_src = '0;
        end else begin
          mask = tail_mask;
          merge_src = rot;
        end
        res = (merge_src & mask) | (aux_q & ~mask);
        aux_we = 1'b0;
      end
      SRM_OP_SAVE: begin
        mask = mode_bit ? '0 : tail_mask;
        merge_src = rot;
        res = rot & mask;
        aux_we = 1'b1;
      end
      default: begin
        mask = tail_mask;
        merge_src = rot;
        res = '0;
        aux_we = 1'b0;
      end
    endcase
  end

  // condition field from the 32-bit result taken as signed
  always_comb begin
    cr0_new.less_than_zero_flag = res[SRM_WORD_W-1];
    cr0_new.greater_than_zero_flag = !res[SRM_WORD_W-1] && (res != '0);
    cr0_new.zero_result_flag = (res == '0);
    cr0_new.summary_ovf = so_q;
  end

  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      SRM_ST_IDLE: if (go_req) state_d = SRM_ST_EXEC;
      SRM_ST_EXEC: state_d = SRM_ST_DONE;
      SRM_ST_DONE: state_d = SRM_ST_IDLE;
      default: state_d = SRM_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= SRM_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // wishbone ack: one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // operand registers; writes while executing are ignored so the
  // operands cannot change under the datapath
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      insn_q <= '0;
      src_q <= '0;
      cnt_q <= '0;
      so_q <= 1'b0;
    end else if (bus_wr && state_q == SRM_ST_IDLE) begin
      case (wb_adr_i)
        SRM_REG_INSN: insn_q <= lane_merge(insn_q, wb_dat_i, wb_sel_i);
        SRM_REG_SRC: src_q <= lane_merge(src_q, wb_dat_i, wb_sel_i);
        SRM_REG_CNT: cnt_q <= lane_merge(cnt_q, wb_dat_i, wb_sel_i);
        SRM_REG_SO: if (wb_sel_i[0]) so_q <= wb_dat_i[0];
        default: begin
        end
      endcase
    end
  end

  // auxiliary holding register: execution beats a bus write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aux_q <= SRM_AUX_RST;
    end else if (state_q == SRM_ST_EXEC) begin
      if (aux_we) begin
        aux_q <= rot;
      end
    end else if (bus_wr && wb_adr_i == SRM_REG_AUX) begin
      aux_q <= lane_merge(aux_q, wb_dat_i, wb_sel_i);
    end
  end

  // result, condition field and per-operation status
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      result_q <= '0;
      cr0_q <= '0;
      ill_q <= 1'b0;
      aux_wr_q <= 1'b0;
      cr0_wr_q <= 1'b0;
    end else if (state_q == SRM_ST_EXEC) begin
      ill_q <= (op == SRM_OP_NONE);
      aux_wr_q <= aux_we;
      cr0_wr_q <= (op != SRM_OP_NONE) && insn_q.record_flag;
      if (op != SRM_OP_NONE) begin
        result_q <= res;
      end
      if (op != SRM_OP_NONE && insn_q.record_flag) begin
        cr0_q <= cr0_new;
      end
    end
  end

  // done flag: completion wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (state_q == SRM_ST_EXEC) begin
      done_q <= 1'b1;
    end else if (clr_req || go_req) begin
      done_q <= 1'b0;
    end
  end

  // write-back pulses; nothing here reaches a carry or overflow
  // register, those stay with the rest of the core
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rf_wr_stb_q <= 1'b0;
      rf_wr_q <= '0;
      cr0_wr_stb_q <= 1'b0;
      cr0_wr_data_q <= '0;
    end else begin
      rf_wr_stb_q <= (state_q == SRM_ST_EXEC) && (op != SRM_OP_NONE);
      cr0_wr_stb_q <= (state_q == SRM_ST_EXEC) && (op != SRM_OP_NONE)
                      && insn_q.record_flag;
      if (state_q == SRM_ST_EXEC && op != SRM_OP_NONE) begin
        rf_wr_q.idx <= insn_q.tgt_idx;
        rf_wr_q.data <= res;
        if (insn_q.record_flag) begin
          cr0_wr_data_q <= cr0_new;
        end
      end
    end
  end

  assign rf_wr_stb = rf_wr_stb_q;
  assign rf_wr = rf_wr_q;
  assign cr0_wr_stb = cr0_wr_stb_q;
  assign cr0_wr = cr0_wr_data_q;

  // read data, registered with the ack; unmapped reads return zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        SRM_REG_CTRL: rdata_q <= '0;
        SRM_REG_INSN: rdata_q <= insn_q;
        SRM_REG_SRC: rdata_q <= src_q;
        SRM_REG_CNT: rdata_q <= cnt_q;
        SRM_REG_AUX: rdata_q <= aux_q;
        SRM_REG_RESULT: rdata_q <= result_q;
        SRM_REG_STATUS: begin
          rdata_q <= '0;
          rdata_q[3:0] <= cr0_q;
          rdata_q[SRM_ST_BUSY] <= (state_q != SRM_ST_IDLE);
          rdata_q[SRM_ST_DONE_BIT] <= done_q;
          rdata_q[SRM_ST_ILL] <= ill_q;
          rdata_q[SRM_ST_AUXW] <= aux_wr_q;
          rdata_q[SRM_ST_IDX_LSB +: 5] <= insn_q.tgt_idx;
          rdata_q[SRM_ST_CR0W] <= cr0_wr_q;
        end
        SRM_REG_SO: rdata_q <= {31'h0000_0000, so_q};
        default: rdata_q <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule // srm_unit

//--- srm_chk.sv
`timescale 1ns/1ps
module srm_chk (
  input logic mclk,
  input logic rst_n,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [4:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic wb_ack_o,
  input logic rf_wr_stb,
  input srm_pkg::srm_wb_t rf_wr,
  input logic cr0_wr_stb,
  input srm_pkg::srm_cr0_t cr0_wr
);
  import srm_pkg::*;
  logic go_w;
  // busy is not a port, so only strobe-implies-go is checked, not go-implies-strobe
  assign go_w = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
    && (wb_adr_i == SRM_REG_CTRL) && wb_sel_i[0] && wb_dat_i[0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_go_two;
    $past(go_w, 2);
  endsequence
  AST_RF_PULSE: assert property (rf_wr_stb |=> !rf_wr_stb)
    else $error("write-back strobe longer than one cycle");
  AST_RF_AFTER_GO: assert property (rf_wr_stb |-> s_go_two)
    else $error("write-back not two cycles after go");
  AST_CR0_AFTER_GO: assert property (cr0_wr_stb |-> s_go_two)
    else $error("condition write not two cycles after go");
  AST_CR0_WITH_RF: assert property (cr0_wr_stb |-> rf_wr_stb)
    else $error("condition write without write-back");
  AST_RF_HOLD: assert property (!rf_wr_stb |-> $stable(rf_wr))
    else $error("write-back value moved without strobe");
  AST_CR0_HOLD: assert property (!cr0_wr_stb |-> $stable(cr0_wr))
    else $error("condition value moved without strobe");
  AST_CR0_LT: assert property (cr0_wr_stb |-> cr0_wr.less_than_zero_flag == rf_wr.data[31])
    else $error("less-than flag wrong");
  AST_CR0_GT: assert property (cr0_wr_stb |->
    cr0_wr.greater_than_zero_flag == (!rf_wr.data[31] && rf_wr.data != 32'h0))
    else $error("greater-than flag wrong");
  AST_CR0_EQ: assert property (cr0_wr_stb |-> cr0_wr.zero_result_flag == (rf_wr.data == 32'h0))
    else $error("zero flag wrong");
endmodule // srm_chk

//--- srm_rf_model.sv
`timescale 1ns/1ps
module srm_rf_model (
  input logic mclk,
  input logic rf_wr_stb,
  input srm_pkg::srm_wb_t rf_wr,
  input logic cr0_wr_stb,
  input srm_pkg::srm_cr0_t cr0_wr
);
  import srm_pkg::*;
  // counters let the bench see every strobe exactly once
  logic [31:0] gpr [32];
  srm_cr0_t cr0_q;
  int n_wr = 0;
  int n_cr0 = 0;
  always @(posedge mclk) begin
    if (rf_wr_stb === 1'b1) begin
      gpr[rf_wr.idx] <= rf_wr.data;
      n_wr <= n_wr + 1;
    end
    if (cr0_wr_stb === 1'b1) begin
      cr0_q <= cr0_wr;
      n_cr0 <= n_cr0 + 1;
    end
  end
endmodule // srm_rf_model

//--- srm_tb.sv
`timescale 1ns/1ps
module shift_right_merge_aux_unit_tb_top;
  import srm_pkg::*;
  typedef struct packed {
    logic [9:0] xo;
    logic rc;
    logic so;
    logic [4:0] sh;
    logic [31:0] cnt;
    logic [31:0] src;
    logic [31:0] aux;
    logic [31:0] res;
    logic [31:0] aux_x;
    logic [3:0] cr0;
  } srm_row_t;
  logic mclk, rst_n, cyc, stb, we, ack, rf_stb, cr0_stb;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, d;
  srm_wb_t rf_wr;
  srm_cr0_t cr0_wr;
  int n_fail = 0;
  int checked = 0;
  int w0;
  srm_row_t rows [9] = '{
    '{SRM_XO_LONG_IMM, 0, 0, 4, 0, 32'h9000300f, 32'h11111111, 32'h19000300, 32'hf9000300, 0},
    '{SRM_XO_LONG_IMM, 1, 0, 4, 0, 32'hb0043000, 32'hffffffff, 32'hfb004300, 32'h0b004300, 8},
    '{SRM_XO_LONG_IMM, 1, 0, 31, 0, 32'h80000001, 32'haaaaaaaa, 32'haaaaaaab, 32'h3, 8},
    '{SRM_XO_LONG_REG, 0, 0, 0, 32'h24, 32'h9000300f, 32'hffffffff, 32'h0fffffff, '1, 0},
    '{SRM_XO_LONG_REG, 1, 0, 0, 32'h4, 32'hb0043000, 32'hffffffff, 32'hfb004300, '1, 8},
    '{SRM_XO_SAVE, 0, 0, 0, 32'h24, 32'h9000300f, 0, 0, 32'hf9000300, 0},
    '{SRM_XO_SAVE, 1, 0, 0, 32'h4, 32'hb000300f, 0, 32'h0b000300, 32'hfb000300, 4},
    '{SRM_XO_SAVE, 1, 1, 0, 32'h0, 32'h12345678, 0, 32'h12345678, 32'h12345678, 5},
    '{SRM_XO_SAVE, 1, 1, 0, 32'h20, 32'h5, 0, 0, 32'h5, 3}};
  srm_unit uut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .rf_wr_stb(rf_stb), .rf_wr(rf_wr), .cr0_wr_stb(cr0_stb), .cr0_wr(cr0_wr));
  srm_rf_model m (.mclk(mclk), .rf_wr_stb(rf_stb), .rf_wr(rf_wr), .cr0_wr_stb(cr0_stb),
    .cr0_wr(cr0_wr));
  task conclude;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle; entered and left just after a rising edge
  task wb(input logic w, input logic [4:0] a, input logic [31:0] v, input logic [3:0] s);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= v;
    sel <= s;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge mclk);
    if (i == 20) begin
      n_fail++;
      conclude;
    end
    d = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask
  task go;
    int i;
    w0 = m.n_wr;
    wb(1, SRM_REG_CTRL, 32'h1, 4'hf);
    for (i = 0; i < 10 && m.n_wr == w0; i++) @(posedge mclk);
    if (i == 10) begin
      n_fail++;
      conclude;
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    srm_row_t r;
    int c0;
    {rst_n, cyc, stb, we, adr, sel, dat_i} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check("rf_wr", 32'(rf_wr), 32'h0);
    wb(0, SRM_REG_AUX, 0, 4'hf);
    check("aux_rst", d, SRM_AUX_RST);
    $display("reset test done");
    for (int k = 0; k < 9; k++) begin
      r = rows[k];
      wb(1, SRM_REG_INSN, {SRM_PRIMARY_OPCD, 5'h4, 5'(k), r.sh, r.xo, r.rc}, 4'hf);
      wb(1, SRM_REG_SRC, r.src, 4'hf);
      wb(1, SRM_REG_CNT, r.cnt, 4'hf);
      wb(1, SRM_REG_AUX, r.aux, 4'hf);
      wb(1, SRM_REG_SO, {31'h0, r.so}, 4'hf);
      c0 = m.n_cr0;
      go();
      repeat (2) @(posedge mclk);
      check("result", m.gpr[k], r.res);
      check("cr0_count", 32'(m.n_cr0 - c0), 32'(r.rc));
      if (r.rc) check("cr0", 32'(m.cr0_q), 32'(r.cr0));
      wb(0, SRM_REG_AUX, 0, 4'hf);
      check("aux", d, r.aux_x);
    end
    $display("instruction table done");
    // lane enables: only the low half of the holding register is cleared
    wb(1, SRM_REG_AUX, 32'hffffffff, 4'hf);
    wb(1, SRM_REG_AUX, 32'h0, 4'h3);
    wb(0, SRM_REG_AUX, 0, 4'hf);
    check("aux_lanes", d, 32'hffff0000);
    wb(1, SRM_REG_INSN, {6'h1e, 5'h4, 5'h9, 5'h0, SRM_XO_SAVE, 1'b1}, 4'hf);
    // no write-back is due here, so wait a fixed span instead of for a strobe
    w0 = m.n_wr;
    wb(1, SRM_REG_CTRL, 32'h1, 4'hf);
    repeat (4) @(posedge mclk);
    check("illegal_wr", 32'(m.n_wr - w0), 32'h0);
    wb(0, SRM_REG_STATUS, 0, 4'hf);
    check("illegal_flag", 32'(d[SRM_ST_ILL]), 32'h1);
    $display("lane and decode tests done");
    conclude;
  end
endmodule // shift_right_merge_aux_unit_tb_top
bind srm_unit srm_chk chk (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .rf_wr_stb(rf_wr_stb), .rf_wr(rf_wr), .cr0_wr_stb(cr0_wr_stb),
  .cr0_wr(cr0_wr));
